// [include/sp_pkg.sv]
/*
 * constants for the multi-mode serial port: register map, field bits,
 * mode codes, reset values and timing counts.
 * assumes a 10 MHz system clock and an 8-bit register port.
 */
package sp_pkg;
	// register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register byte addresses
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] CTRL0_OFS = 8'h04;
	localparam logic [7:0] CTRL1_OFS = 8'h08;
	localparam logic [7:0] SMR3_OFS = 8'h0c;
	localparam logic [7:0] SMR4_OFS = 8'h10;
	localparam logic [7:0] TXBUF_OFS = 8'h14;
	localparam logic [7:0] RXBUF_OFS = 8'h18;
	localparam logic [7:0] STAT_OFS = 8'h1c;
	localparam logic [7:0] MASK_OFS = 8'h20;
	// serial_mode_field codes
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_SYNC = 3'h1;
	localparam logic [2:0] MODE_I2C = 3'h2;
	localparam logic [2:0] MODE_ASYNC = 3'h4;
	localparam logic [2:0] MODE_SCARD = 3'h5;
	// serial_control_zero bits
	localparam int C0_INTCLK = 0;
	localparam int C0_POL = 1;
	localparam int C0_CTS_EN = 2;
	localparam int C0_RTS_EN = 3;
	// serial_control_one bits
	localparam int C1_TX_ALLOW = 0;
	localparam int C1_TX_EMPTY = 1;
	localparam int C1_RX_ALLOW = 2;
	localparam int C1_RX_FULL = 3;
	localparam int C1_IRQ_SRC = 4;
	localparam int C1_ERR_EN = 5;
	// special_mode_three_reg / special_mode_four_reg bits
	localparam int S3_OD = 0;
	localparam int S4_START = 0;
	localparam int S4_RESTART = 1;
	localparam int S4_STOP = 2;
	localparam int S4_SEL = 3;
	// interrupt status / mask bits
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_COND = 2;
	// reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;
	// frame lengths in bits
	localparam logic [3:0] LEN_SYNC = 4'h8;
	localparam logic [3:0] LEN_ASYNC = 4'ha;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int COND_HALF_NS = 2000;
	localparam int INT_HALF_NS = 400;
	localparam int COND_HALF_CYC =
		(COND_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_HALF_CYC =
		(INT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] COND_HALF = 8'(COND_HALF_CYC - 1);
	localparam logic [7:0] INT_HALF = 8'(INT_HALF_CYC - 1);
	// condition generator states
	typedef enum logic [2:0] {
		CS_IDLE, CS_LOW, CS_PRE, CS_POST, CS_TAIL
	} sp_cond_st_t;
endpackage

// [src/sp_serial_port.sv]
/*
 * multi-mode serial port: clock-synchronous, asynchronous, smart-card
 * and i2c condition generation, with receive-request flow control.
 * assumes an 8-bit register port on sys_clk and pins from outside the
 * clock domain; the serial clock pin is sampled, never used as a clock.
 */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sp_serial_port import sp_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [DATA_W-1:0] reg_rdata,
	output logic irq,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe,
	input wire logic clear_to_send_in,
	output logic receive_request_out
);
	// software registers
	logic [2:0] mode_q, mode_d;
	logic [3:0] c0_q, c0_d;
	logic [5:0] c1_q, c1_d;
	logic od_q, od_d;
	logic [3:0] s4_q, s4_d;
	logic [2:0] arm_q, arm_d; // requests taken on a rising edge
	logic [7:0] txbuf_q, txbuf_d;
	logic [7:0] rxbuf_q, rxbuf_d;
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q, mask_d;
	logic sc_prev_q, sc_prev_d; // smart-card trigger, last cycle
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	// synchronisers: first stage read only by the second
	logic lk_s1_q, lk_s2_q, lk_s3_q;
	logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q;
	// transfer engine
	logic ic_q, ic_d; // internal serial clock level
	logic [7:0] ic_cnt_q, ic_cnt_d;
	logic tx_busy_q, tx_busy_d;
	logic [9:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_cnt_q, tx_cnt_d;
	logic tx_line_q, tx_line_d;
	logic rx_act_q, rx_act_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [3:0] rx_cnt_q, rx_cnt_d;
	logic rts_q, rts_d;
	// condition generator
	sp_cond_st_t cs_q, cs_d;
	logic [7:0] cs_cnt_q, cs_cnt_d;
	logic [1:0] cs_kind_q, cs_kind_d; // 0 start, 1 restart, 2 stop
	logic scl_lvl, sda_lvl;
	// pins
	logic ck_o_q, ck_o_d, ck_oe_q, ck_oe_d;
	logic d_o_q, d_o_d, d_oe_q, d_oe_d;
	// shared decodes
	logic wr_txbuf, rd_rxbuf, active, async_fmt, int_clk, pol;
	logic ck, idle_hi, rise, fall, shift_e, samp_e, ic_tog;
	logic tx_go, tx_load_ev, tx_done_ev, rx_done_ev, cond_ev, sc_trig;

	assign wr_txbuf = reg_we && reg_addr == TXBUF_OFS;
	assign rd_rxbuf = reg_re && reg_addr == RXBUF_OFS;
	assign active = mode_q == MODE_SYNC || mode_q == MODE_ASYNC ||
		mode_q == MODE_SCARD;
	assign async_fmt = mode_q == MODE_ASYNC || mode_q == MODE_SCARD;
	assign int_clk = c0_q[C0_INTCLK];
	assign pol = c0_q[C0_POL];
	assign idle_hi = ~pol;
	assign ck = int_clk ? ic_q : lk_s2_q;
	assign ic_tog = tx_busy_q && ic_cnt_q == INT_HALF;
	// edges of the serial clock, internal or sampled
	assign rise = int_clk ? (ic_tog && !ic_q) : (lk_s2_q && !lk_s3_q);
	assign fall = int_clk ? (ic_tog && ic_q) : (!lk_s2_q && lk_s3_q);
	assign shift_e = pol ? rise : fall;
	assign samp_e = pol ? fall : rise;
	// start conditions; a buffer write wins the cycle
	assign tx_go = active && !tx_busy_q && c1_q[C1_TX_ALLOW] &&
		!c1_q[C1_TX_EMPTY] && (!c0_q[C0_CTS_EN] || !cts_s2_q) &&
		(int_clk || ck == idle_hi) && !wr_txbuf;
	assign tx_load_ev = tx_go;
	// sync ends on the last bit's sample edge: eight partner clocks do
	assign tx_done_ev = tx_busy_q && (async_fmt ?
		(shift_e && tx_cnt_q == LEN_ASYNC) :
		(samp_e && tx_cnt_q == LEN_SYNC));
	assign rx_done_ev = rx_act_q && samp_e && rx_cnt_q == 4'h7;
	assign sc_trig = mode_q == MODE_SCARD && c1_q[C1_IRQ_SRC] &&
		c1_q[C1_ERR_EN];
	assign cond_ev = cs_q == CS_TAIL && cs_cnt_q == COND_HALF;

	// pin synchronisers, two stages plus an edge history
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			// idle high like the pulled-up pin: no false edge after reset
			lk_s1_q <= 1'b1;
			lk_s2_q <= 1'b1;
			lk_s3_q <= 1'b1;
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			cts_s1_q <= 1'b1;
			cts_s2_q <= 1'b1;
		end else begin
			lk_s1_q <= serial_clock_pin_in;
			lk_s2_q <= lk_s1_q;
			lk_s3_q <= lk_s2_q;
			rx_s1_q <= data_in;
			rx_s2_q <= rx_s1_q;
			cts_s1_q <= clear_to_send_in;
			cts_s2_q <= cts_s1_q;
		end
	end

	// register file next state
	always_comb begin
		mode_d = mode_q;
		c0_d = c0_q;
		c1_d = c1_q;
		od_d = od_q;
		s4_d = s4_q;
		arm_d = arm_q;
		txbuf_d = txbuf_q;
		rxbuf_d = rxbuf_q;
		stat_d = stat_q;
		mask_d = mask_q;
		rdata_d = '0;
		if (reg_we) begin
			unique case (reg_addr)
				MODE_OFS: mode_d = reg_wdata[2:0];
				CTRL0_OFS: c0_d = reg_wdata[3:0];
				CTRL1_OFS: begin
					// flags in this register are read only
					c1_d[C1_TX_ALLOW] = reg_wdata[C1_TX_ALLOW];
					c1_d[C1_RX_ALLOW] = reg_wdata[C1_RX_ALLOW];
					c1_d[C1_IRQ_SRC] = reg_wdata[C1_IRQ_SRC];
					c1_d[C1_ERR_EN] = reg_wdata[C1_ERR_EN];
				end
				SMR3_OFS: od_d = reg_wdata[S3_OD];
				SMR4_OFS: begin
					s4_d = reg_wdata[3:0];
					// arm on a 0-to-1 request with select on
					// requests made with select off never fire
					if (reg_wdata[S4_SEL] && mode_q == MODE_I2C) begin
						arm_d = arm_q | (reg_wdata[2:0] & ~s4_q[2:0]);
					end
				end
				TXBUF_OFS: begin
					txbuf_d = reg_wdata;
					c1_d[C1_TX_EMPTY] = 1'b0;
				end
				STAT_OFS: stat_d = stat_q & ~reg_wdata[2:0];
				MASK_OFS: mask_d = reg_wdata[2:0];
				default: ;
			endcase
		end
		if (reg_re) begin
			unique case (reg_addr)
				MODE_OFS: rdata_d = {5'h00, mode_q};
				CTRL0_OFS: rdata_d = {4'h0, c0_q};
				CTRL1_OFS: rdata_d = {2'h0, c1_q};
				SMR3_OFS: rdata_d = {7'h00, od_q};
				SMR4_OFS: rdata_d = {4'h0, s4_q};
				TXBUF_OFS: rdata_d = txbuf_q;
				RXBUF_OFS: rdata_d = rxbuf_q;
				STAT_OFS: rdata_d = {5'h00, stat_q};
				MASK_OFS: rdata_d = {5'h00, mask_q};
				default: rdata_d = '0; // unmapped reads zero
			endcase
		end
		// reading the receive buffer frees it
		if (rd_rxbuf) begin
			c1_d[C1_RX_FULL] = 1'b0;
		end
		// hardware sets below override software clears
		if (tx_load_ev) begin
			c1_d[C1_TX_EMPTY] = 1'b1;
		end
		if (rx_done_ev) begin
			rxbuf_d = {rx_s2_q, rx_sh_q[7:1]};
			c1_d[C1_RX_FULL] = 1'b1;
		end
		// finished condition drops its request bit
		if (cond_ev) begin
			s4_d[cs_kind_q] = 1'b0;
			arm_d[cs_kind_q] = 1'b0;
		end
		if ((tx_load_ev && !c1_q[C1_IRQ_SRC]) ||
			(tx_done_ev && c1_q[C1_IRQ_SRC])) begin
			stat_d[IRQ_TX] = 1'b1;
		end
		// raise at once; software then clears it
		if (sc_trig && !sc_prev_q) begin
			stat_d[IRQ_TX] = 1'b1;
		end
		if (rx_done_ev) begin
			stat_d[IRQ_RX] = 1'b1;
		end
		if (cond_ev) begin
			stat_d[IRQ_COND] = 1'b1;
		end
		sc_prev_d = sc_trig;
		irq_d = |(stat_d & mask_d);
	end

	// register file flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= MODE_OFF;
			c0_q <= '0;
			c1_q <= 6'h02; // transmit buffer starts empty
			od_q <= 1'b0;
			s4_q <= '0;
			arm_q <= '0;
			txbuf_q <= REG_RST;
			rxbuf_q <= REG_RST;
			stat_q <= '0;
			mask_q <= '0;
			sc_prev_q <= 1'b0;
			rdata_q <= REG_RST;
			irq_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			c0_q <= c0_d;
			c1_q <= c1_d;
			od_q <= od_d;
			s4_q <= s4_d;
			arm_q <= arm_d;
			txbuf_q <= txbuf_d;
			rxbuf_q <= rxbuf_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			sc_prev_q <= sc_prev_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	// transfer engine next state
	always_comb begin
		ic_d = ic_q;
		ic_cnt_d = ic_cnt_q;
		tx_busy_d = tx_busy_q;
		tx_sh_d = tx_sh_q;
		tx_cnt_d = tx_cnt_q;
		tx_line_d = tx_line_q;
		rx_act_d = rx_act_q;
		rx_sh_d = rx_sh_q;
		rx_cnt_d = rx_cnt_q;
		// internal clock only runs during a transmit frame
		if (!tx_busy_q) begin
			ic_d = idle_hi;
			ic_cnt_d = '0;
		end else if (ic_tog) begin
			ic_d = ~ic_q;
			ic_cnt_d = '0;
		end else begin
			ic_cnt_d = ic_cnt_q + 8'h01;
		end
		if (tx_go) begin
			tx_busy_d = 1'b1;
			tx_cnt_d = CNT_RST;
			// async frames carry start and stop bits
			tx_sh_d = async_fmt ? {1'b1, txbuf_q, 1'b0} :
				{2'b11, txbuf_q};
		end else if (tx_done_ev) begin
			tx_busy_d = 1'b0;
			// sync holds its last bit past the final sample edge
			tx_line_d = async_fmt ? 1'b1 : tx_line_q;
		end else if (tx_busy_q && shift_e) begin
			// data changes on the shift edge
			tx_line_d = tx_sh_q[0];
			tx_sh_d = {1'b1, tx_sh_q[9:1]};
			tx_cnt_d = tx_cnt_q + 4'h1;
		end
		// data sampled on the opposite edge
		if (!active || !c1_q[C1_RX_ALLOW]) begin
			rx_act_d = 1'b0;
			rx_cnt_d = CNT_RST;
		end else if (samp_e) begin
			if (rx_act_q) begin
				rx_sh_d = {rx_s2_q, rx_sh_q[7:1]};
				rx_cnt_d = rx_cnt_q + 4'h1;
				if (rx_done_ev) begin
					rx_act_d = 1'b0;
				end
			end else if (!async_fmt) begin
				// sync: first edge already carries bit 0
				rx_act_d = 1'b1;
				rx_sh_d = {rx_s2_q, rx_sh_q[7:1]};
				rx_cnt_d = 4'h1;
			end else if (!rx_s2_q) begin
				// async: low start bit opens the frame
				rx_act_d = 1'b1;
				rx_cnt_d = CNT_RST;
			end
		end
		// flow control only with external clock
		// high from the cycle receiving begins
		rts_d = !(c0_q[C0_RTS_EN] && !int_clk && active &&
			c1_q[C1_RX_ALLOW] && !rx_act_d);
	end

	// transfer engine flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ic_q <= 1'b1;
			ic_cnt_q <= '0;
			tx_busy_q <= 1'b0;
			tx_sh_q <= '1;
			tx_cnt_q <= CNT_RST;
			tx_line_q <= 1'b1;
			rx_act_q <= 1'b0;
			rx_sh_q <= '0;
			rx_cnt_q <= CNT_RST;
			rts_q <= 1'b1;
		end else begin
			ic_q <= ic_d;
			ic_cnt_q <= ic_cnt_d;
			tx_busy_q <= tx_busy_d;
			tx_sh_q <= tx_sh_d;
			tx_cnt_q <= tx_cnt_d;
			tx_line_q <= tx_line_d;
			rx_act_q <= rx_act_d;
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			rts_q <= rts_d;
		end
	end

	// condition generator and pin drive, next state
	always_comb begin
		cs_d = cs_q;
		cs_cnt_d = cs_cnt_q + 8'h01;
		cs_kind_d = cs_kind_q;
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		// each phase lasts one half period
		if (cs_q == CS_IDLE || cs_cnt_q == COND_HALF) begin
			cs_cnt_d = '0;
		end
		// conditions only while select stays on
		unique case (cs_q)
			CS_IDLE: begin
				if (s4_q[S4_SEL] && mode_q == MODE_I2C && |arm_q) begin
					cs_kind_d = arm_q[S4_START] ? 2'd0 :
						(arm_q[S4_RESTART] ? 2'd1 : 2'd2);
					cs_d = arm_q[S4_START] ? CS_PRE : CS_LOW;
				end
			end
			CS_LOW: begin
				scl_lvl = 1'b0;
				sda_lvl = cs_kind_q == 2'd2 ? 1'b0 : 1'b1;
				if (cs_cnt_q == COND_HALF) cs_d = CS_PRE;
			end
			CS_PRE: begin
				sda_lvl = cs_kind_q == 2'd2 ? 1'b0 : 1'b1;
				if (cs_cnt_q == COND_HALF) cs_d = CS_POST;
			end
			CS_POST: begin
				sda_lvl = cs_kind_q == 2'd2 ? 1'b1 : 1'b0;
				if (cs_cnt_q == COND_HALF) cs_d = CS_TAIL;
			end
			CS_TAIL: begin
				// stop leaves both lines released high
				scl_lvl = cs_kind_q == 2'd2;
				sda_lvl = cs_kind_q == 2'd2;
				if (cs_cnt_q == COND_HALF) cs_d = CS_IDLE;
			end
		endcase
		if (!s4_q[S4_SEL] || mode_q != MODE_I2C) begin
			cs_d = CS_IDLE;
		end
		// pins: port function while the mode is off
		ck_o_d = 1'b0;
		ck_oe_d = 1'b0;
		d_o_d = 1'b0;
		d_oe_d = 1'b0;
		if (mode_q == MODE_I2C) begin
			// open-drain lines, driven only during a condition
			if (cs_q != CS_IDLE) begin
				ck_oe_d = !scl_lvl;
				d_oe_d = !sda_lvl;
			end
		end else if (mode_q != MODE_OFF) begin
			d_o_d = tx_line_q;
			d_oe_d = 1'b1;
			// open drain counts only with a mode set
			if (int_clk) begin
				ck_o_d = od_q ? 1'b0 : ic_q;
				ck_oe_d = od_q ? !ic_q : 1'b1;
			end
		end
	end

	// condition generator and pin flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_q <= CS_IDLE;
			cs_cnt_q <= '0;
			cs_kind_q <= 2'd0;
			ck_o_q <= 1'b0;
			ck_oe_q <= 1'b0;
			d_o_q <= 1'b0;
			d_oe_q <= 1'b0;
		end else begin
			cs_q <= cs_d;
			cs_cnt_q <= cs_cnt_d;
			cs_kind_q <= cs_kind_d;
			ck_o_q <= ck_o_d;
			ck_oe_q <= ck_oe_d;
			d_o_q <= d_o_d;
			d_oe_q <= d_oe_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign receive_request_out = rts_q;
	assign serial_clock_pin_out = ck_o_q;
	assign serial_clock_pin_oe = ck_oe_q;
	assign data_out = d_o_q;
	assign data_oe = d_oe_q;
endmodule

// [bench/sp_serial_port_chk.sv]
/* checker: port assertions for sp_serial_port, bound from the bench.
 assumes one clock domain; register writes are shadowed here. */
`timescale 1ns/1ps
module sp_serial_port_chk import sp_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic irq,
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic data_in,
	input wire logic data_out,
	input wire logic data_oe,
	input wire logic clear_to_send_in,
	input wire logic receive_request_out
);
	// shadow of mode, control zero and condition select
	logic [2:0] mode_q, mode_d;
	logic [3:0] c0_q, c0_d;
	logic sel_q, sel_d;
	// next shadow values, taken from writes only
	always_comb begin
		mode_d = (reg_we && reg_addr == MODE_OFS) ? reg_wdata[2:0] : mode_q;
		c0_d = (reg_we && reg_addr == CTRL0_OFS) ? reg_wdata[3:0] : c0_q;
		sel_d = (reg_we && reg_addr == SMR4_OFS) ? reg_wdata[S4_SEL] : sel_q;
	end
	// shadow registers, cleared like the design
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{mode_q, c0_q, sel_q} <= 8'h00;
		end else begin
			{mode_q, c0_q, sel_q} <= {mode_d, c0_d, sel_d};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_reset_quiet: assert property ($rose(rst_b) |-> receive_request_out
		&& !irq && !data_oe && !serial_clock_pin_oe)
		else $error("outputs not quiet after reset");
	a_rts_int_off: assert property (
		c0_q[C0_INTCLK] && $past(c0_q[C0_INTCLK]) |-> receive_request_out)
		else $error("request low with internal clock");
	a_rts_rise: assert property (
		$rose(receive_request_out) && !$past(reg_we) && !$past(reg_we, 2)
		|-> $past(serial_clock_pin_in, 2) != $past(serial_clock_pin_in, 6))
		else $error("request rose without a clock edge");
	a_ext_no_drive: assert property (
		!c0_q[C0_INTCLK] && $past(!c0_q[C0_INTCLK]) && mode_q != MODE_I2C
		&& $stable(mode_q) |-> !serial_clock_pin_oe)
		else $error("external clock pin driven");
	a_mode_off_free: assert property (
		mode_q == MODE_OFF && $stable(mode_q) |-> !data_oe
		&& !serial_clock_pin_oe)
		else $error("pins driven with mode off");
	a_sel_quiet: assert property (
		mode_q == MODE_I2C && $stable(mode_q) && !sel_q && $past(!sel_q)
		&& $past(!sel_q, 2)
		|-> !data_oe && !serial_clock_pin_oe)
		else $error("condition lines driven with select off");
	a_sda_open: assert property (
		mode_q == MODE_I2C && $stable(mode_q) && data_oe |-> !data_out)
		else $error("data line driven high in i2c");
	a_shift_fall: assert property (
		mode_q == MODE_SYNC && !c0_q[C0_INTCLK] && !c0_q[C0_POL]
		&& $changed(data_out) && !$past(reg_we) && !$past(reg_we, 2)
		|-> $past(serial_clock_pin_in, 6) && !$past(serial_clock_pin_in))
		else $error("data changed away from a falling edge");
	c_rx_start: cover property ($rose(receive_request_out));
	c_cond_drive: cover property (mode_q == MODE_I2C && data_oe);
	c_irq_up: cover property ($rose(irq));
endmodule

// [bench/sp_peer.sv]
/* peer: external clocking partner for clock-synchronous frames.
 polarity given per frame; the bench parks the clock between frames. */
`timescale 1ns/1ps
module sp_peer (
	output logic sclk,
	output logic sdata,
	input wire logic rx_line
);
	initial begin
		sclk = 1'b1;
		sdata = 1'b1;
	end
	// idle level set ahead of a polarity change
	task automatic park(input logic lvl);
		sclk = lvl;
	endtask
	// leading edge shifts, sample mid-way through the trailing phase for margin
	// 800 ns clock, lsb first
	task automatic xfer(input logic pol, input logic [7:0] tx,
		output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			sclk = pol;
			sdata = tx[i];
			#400 sclk = ~pol;
			#200 rx[i] = rx_line;
			#200;
		end
		// hold time over: no pull, so show the inverse
		sdata = ~sdata;
	endtask
endmodule

// [bench/tb.sv]
/* bench: drives the serial port via its register port and a peer.
 assumes sp_pkg, the design, the peer and the checker are compiled. */
`timescale 1ns/1ps
module tb import sp_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic clear_to_send_in = 1'b1;
	logic [7:0] reg_rdata, b, got;
	logic irq, serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
	logic data_in, data_out, data_oe, receive_request_out, peer_sck;
	logic [7:0] rxq[$];
	int err_count = 0;
	int compares = 0;
	int m_st = 0;
	int m_mk = 0;
	int at[3] = '{30, 50, 10};
	always #50 sys_clk = ~sys_clk;
	// clock wire: pull-up, either party may pull low
	assign serial_clock_pin_in = peer_sck
		& (serial_clock_pin_oe ? serial_clock_pin_out : 1'b1);
	sp_serial_port u_sp_serial_port (.sys_clk, .rst_b, .reg_addr,
		.reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq, .serial_clock_pin_in,
		.serial_clock_pin_out, .serial_clock_pin_oe, .data_in, .data_out,
		.data_oe, .clear_to_send_in, .receive_request_out);
	sp_peer u_sp_peer (.sclk(peer_sck), .sdata(data_in), .rx_line(data_out));
	// one compare, counted
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_we <= 1'b0;
		#1;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// level interrupt against the status and mask model
	task automatic irq_chk;
		cyc(2);
		chk({7'h0, irq}, {7'h0, (m_st & m_mk) != 0});
	endtask
	task automatic wrap_up;
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog, nearly thirty times the expected run
	initial begin
		#2_000_000;
		err_count++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'hde3426a3));
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(CTRL1_OFS, 8'h02);
		wr(8'h24, 8'hff);
		rd(8'h24, 8'h00);
		wr(MODE_OFS, {5'h0, MODE_SYNC});
		wr(CTRL1_OFS, 8'h04);
		wr(CTRL0_OFS, 8'h09);
		cyc(3);
		chk({7'h0, receive_request_out}, 8'h01);
		wr(CTRL0_OFS, 8'h08);
		cyc(3);
		chk({7'h0, receive_request_out}, 8'h00);
		b = 8'($urandom);
		rxq.push_back(b);
		fork
			u_sp_peer.xfer(1'b0, b, got);
			begin
				cyc(14);
				chk({7'h0, receive_request_out}, 8'h01);
			end
		join
		cyc(4);
		chk({7'h0, receive_request_out}, 8'h00);
		rd(RXBUF_OFS, rxq.pop_front());
		// clear-to-send high holds the frame back
		wr(CTRL0_OFS, 8'h04);
		b = 8'($urandom);
		wr(TXBUF_OFS, b);
		wr(CTRL1_OFS, 8'h05);
		cyc(4);
		rd(CTRL1_OFS, 8'h05);
		@(posedge sys_clk);
		clear_to_send_in <= 1'b0;
		cyc(6);
		rd(CTRL1_OFS, 8'h07);
		rxq.push_back(8'($urandom));
		u_sp_peer.xfer(1'b0, rxq[0], got);
		chk(got, b);
		rd(RXBUF_OFS, rxq.pop_front());
		// polarity 1: park the clock low before switching
		u_sp_peer.park(1'b0);
		cyc(4);
		wr(CTRL0_OFS, 8'h02);
		b = 8'($urandom);
		wr(TXBUF_OFS, b);
		rxq.push_back(8'($urandom));
		cyc(6);
		u_sp_peer.xfer(1'b1, rxq[0], got);
		chk(got, b);
		rd(RXBUF_OFS, rxq.pop_front());
		u_sp_peer.park(1'b1);
		cyc(4);
		m_st = 3;
		rd(STAT_OFS, 8'(m_st));
		irq_chk;
		wr(MASK_OFS, 8'h07);
		m_mk = 7;
		irq_chk;
		wr(STAT_OFS, 8'(m_st));
		m_st = 0;
		irq_chk;
		wr(MODE_OFS, {5'h0, MODE_SCARD});
		wr(CTRL1_OFS, 8'h30);
		m_st = 1;
		irq_chk;
		rd(STAT_OFS, 8'h01);
		wr(MASK_OFS, 8'h00);
		m_mk = 0;
		irq_chk;
		wr(STAT_OFS, 8'h01);
		wr(MASK_OFS, 8'h07);
		m_st = 0;
		m_mk = 7;
		irq_chk;
		wr(MODE_OFS, {5'h0, MODE_I2C});
		wr(SMR4_OFS, 8'h01);
		cyc(30);
		chk({7'h0, data_oe}, 8'h00);
		rd(STAT_OFS, 8'h00);
		// start, restart and stop in turn
		for (int k = 0; k < 3; k++) begin
			// select off, then over half a transfer clock
			wr(SMR4_OFS, 8'h00);
			cyc(COND_HALF_CYC + 2);
			wr(SMR4_OFS, 8'h08 | 8'(1 << k));
			cyc(at[k]);
			chk({6'h0, data_oe, data_out}, 8'h02);
			cyc(4 * COND_HALF_CYC - at[k] + 4);
			rd(SMR4_OFS, 8'h08);
			m_st = 4;
			irq_chk;
			wr(STAT_OFS, 8'h04);
			m_st = 0;
		end
		wr(MODE_OFS, {5'h0, MODE_SYNC});
		wr(CTRL0_OFS, 8'h01);
		wr(SMR3_OFS, 8'h01);
		cyc(2);
		chk({7'h0, serial_clock_pin_out}, 8'h00);
		wr(SMR3_OFS, 8'h00);
		wr(MODE_OFS, 8'h00);
		cyc(3);
		chk({6'h0, serial_clock_pin_oe, data_oe}, 8'h00);
		wrap_up;
	end
endmodule
bind sp_serial_port sp_serial_port_chk u_chk (.sys_clk, .rst_b, .reg_addr,
	.reg_wdata, .reg_we, .reg_re, .reg_rdata, .irq, .serial_clock_pin_in,
	.serial_clock_pin_out, .serial_clock_pin_oe, .data_in, .data_out,
	.data_oe, .clear_to_send_in, .receive_request_out);
